// ===== uts_core.sv
module uts_core
  import uts_pkg::*;
#(
  parameter int AW = 8
)(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_cyc,
  input wire logic i_stb,
  input wire logic i_we,
  input wire logic [AW-1:0] i_adr,
  input wire logic [3:0] i_sel,
  input wire logic [31:0] i_dat,
  output logic [31:0] o_dat,
  output logic o_ack,
  input wire logic i_baud_tick,
  input wire logic i_start_bit,
  input wire logic i_rx_byte_done,
  input wire logic [8:0] i_rx_data,
  input wire logic i_parity_err,
  input wire logic i_frame_err,
  input wire logic i_noise,
  input wire logic i_idle,
  input wire logic i_lin_break,
  input wire logic i_tx_shift_load,
  input wire logic i_tx_last_done,
  input wire logic i_break_stop_sent,
  input wire logic i_autobaud_done,
  input wire logic i_mute_wakeup,
  input wire logic i_clear_to_send_input_b,
  output logic [8:0] o_tx_data,
  output logic o_tx_write,
  output logic o_autobaud_run,
  output logic o_mute_enter,
  output logic o_rx_flush,
  output logic o_tx_cancel,
  output logic o_break_pending,
  output logic o_smartcard_mode,
  output logic o_receiver_enable,
  output logic o_lin_break_irq,
  output logic o_end_of_block_irq
);
  function automatic logic hit(input logic [AW-1:0] a, input logic [7:0] ofs);
    hit = (a == AW'(ofs));
  endfunction

  logic ack;
  logic [31:0] timeout_reg;
  logic [CT_W-1:0] ctrl;
  logic [31:0] flags;
  logic [31:0] set_v;
  logic [31:0] clr_v;
  logic [23:0] tmo_cnt;
  logic tmo_run;
  logic tmo_hit;
  logic [8:0] blk_cnt;
  logic blk_clr;
  logic eob_hit;
  logic cts_s1;
  logic cts_s2;
  logic cts_s3;
  logic acc;
  logic wr;
  logic rd;
  logic [31:0] wmask;
  logic [RQ_W-1:0] rq;
  logic fc_eob;
  logic data_rd;
  logic data_wr;
  logic sc;

  assign o_ack = ack;
  assign sc = ctrl[CT_SMARTCARD];
  assign o_smartcard_mode = ctrl[CT_SMARTCARD];
  assign o_receiver_enable = ctrl[CT_RX_EN];
  assign o_break_pending = flags[ST_BREAK];
  assign o_lin_break_irq = flags[ST_LIN] & ctrl[CT_LIN_IE];
  assign o_end_of_block_irq = flags[ST_EOB] & ctrl[CT_EOB_IE];

  // Writes land on the edge where the master sees ack
  assign acc = i_cyc & i_stb & ack & i_ce;
  assign wr = acc & i_we;
  assign rd = acc & ~i_we;
  assign wmask = {{8{i_sel[3]}}, {8{i_sel[2]}}, {8{i_sel[1]}}, {8{i_sel[0]}}};
  assign rq = (wr && hit(i_adr, OFS_REQUEST)) ? i_dat[RQ_W-1:0] & wmask[RQ_W-1:0] : '0;
  assign fc_eob = wr & hit(i_adr, OFS_FLAG_CLR) & i_dat[ST_EOB] & i_sel[1];
  assign data_rd = rd & hit(i_adr, OFS_DATA);
  assign data_wr = wr & hit(i_adr, OFS_DATA) & i_sel[0];

  always_ff @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b)
      ack <= 1'b0;
    else if (i_ce)
      ack <= i_cyc & i_stb & ~ack;

  always_ff @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b)
      o_dat <= '0;
    else if (i_ce && i_cyc && i_stb && !ack)
    begin
      // Request and flag-clear read zero; unmapped reads zero too
      if (hit(i_adr, OFS_TIMEOUT))
        o_dat <= timeout_reg;
      else if (hit(i_adr, OFS_STATUS))
        o_dat <= flags;
      else if (hit(i_adr, OFS_CONTROL))
        o_dat <= {{(32-CT_W){1'b0}}, ctrl};
      else if (hit(i_adr, OFS_DATA))
        o_dat <= {23'h0, i_rx_data};
      else
        o_dat <= '0;
    end

  // Timeout value and block length share one word
  always_ff @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b)
      timeout_reg <= RST_TIMEOUT;
    else if (wr && hit(i_adr, OFS_TIMEOUT))
      timeout_reg <= (timeout_reg & ~wmask) | (i_dat & wmask);

  always_ff @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b)
      ctrl <= RST_CONTROL;
    else if (wr && hit(i_adr, OFS_CONTROL) && i_sel[0])
      ctrl <= i_dat[CT_W-1:0];

  always_ff @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b)
    begin
      o_tx_data <= '0;
      o_tx_write <= 1'b0;
    end
    else if (i_ce)
    begin
      o_tx_write <= data_wr;
      if (data_wr)
        o_tx_data <= i_dat[8:0];
    end

  // Request outputs are one-cycle pulses; only the break request is stored, as the break flag
  always_ff @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b)
    begin
      o_autobaud_run <= 1'b0;
      o_mute_enter <= 1'b0;
      o_rx_flush <= 1'b0;
      o_tx_cancel <= 1'b0;
    end
    else if (i_ce)
    begin
      o_autobaud_run <= rq[RQ_AUTOBAUD];
      o_mute_enter <= rq[RQ_MUTE];
      o_rx_flush <= rq[RQ_RX_FLUSH];
      o_tx_cancel <= rq[RQ_TX_FLUSH];
    end

  // Clear-to-send pin synchroniser plus one stage for edge compare
  always_ff @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b)
    begin
      cts_s1 <= 1'b1;
      cts_s2 <= 1'b1;
      cts_s3 <= 1'b1;
    end
    else if (i_ce)
    begin
      cts_s1 <= i_clear_to_send_input_b;
      cts_s2 <= cts_s1;
      cts_s3 <= cts_s2;
    end

  // Zero timeout value disables the counter rather than firing at once
  assign tmo_hit = tmo_run & i_baud_tick & (tmo_cnt + 24'h1 == timeout_reg[TMO_LSB +: TMO_W]);

  always_ff @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b)
    begin
      tmo_cnt <= '0;
      tmo_run <= 1'b0;
    end
    else if (i_ce)
    begin
      if (timeout_reg[TMO_LSB +: TMO_W] == '0)
        tmo_run <= 1'b0;
      else if (sc ? i_start_bit : i_rx_byte_done)
      begin
        tmo_cnt <= '0;
        tmo_run <= 1'b1;
      end
      else if (!sc && i_start_bit)
        tmo_run <= 1'b0;
      else if (tmo_hit)
        tmo_run <= 1'b0;
      else if (tmo_run && i_baud_tick)
        tmo_cnt <= tmo_cnt + 24'h1;
    end

  assign blk_clr = ~ctrl[CT_RX_EN] | fc_eob | (sc & ~flags[ST_TXBE]);
  assign eob_hit = sc & i_rx_byte_done & ~blk_clr
    & (blk_cnt + 9'h1 == {1'b0, timeout_reg[BLOCK_LENGTH_LSB +: BLOCK_LENGTH_W]} + BLOCK_EXTRA);

  always_ff @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b)
      blk_cnt <= '0;
    else if (i_ce)
    begin
      if (blk_clr)
        blk_cnt <= '0;
      else if (sc && i_rx_byte_done && blk_cnt != 9'h1ff)
        blk_cnt <= blk_cnt + 9'h1;
    end

  // Set terms are applied after clears, so a coincident event wins
  always_comb
  begin
    set_v = '0;
    clr_v = '0;
    if (wr && hit(i_adr, OFS_FLAG_CLR))
      clr_v = i_dat & wmask & FC_MASK;
    clr_v[ST_AUTOBAUD] = rq[RQ_AUTOBAUD];
    clr_v[ST_MUTE] = rq[RQ_MUTE];
    clr_v[ST_RXNE] = data_rd | rq[RQ_RX_FLUSH];
    clr_v[ST_TXC] = clr_v[ST_TXC] | data_wr;
    clr_v[ST_TXBE] = data_wr;
    clr_v[ST_BREAK] = i_break_stop_sent;
    set_v[ST_PARITY] = i_parity_err;
    set_v[ST_FRAMING] = i_frame_err;
    set_v[ST_NOISE] = i_noise;
    set_v[ST_OVERRUN] = i_rx_byte_done & flags[ST_RXNE];
    set_v[ST_IDLE] = i_idle;
    set_v[ST_RXNE] = i_rx_byte_done;
    set_v[ST_TXC] = i_tx_last_done & flags[ST_TXBE];
    set_v[ST_TXBE] = i_tx_shift_load | rq[RQ_TX_FLUSH];
    set_v[ST_LIN] = i_lin_break;
    set_v[ST_CTS] = cts_s2 ^ cts_s3;
    set_v[ST_TIMEOUT] = tmo_hit;
    set_v[ST_EOB] = eob_hit;
    set_v[ST_AUTOBAUD] = i_autobaud_done;
    set_v[ST_BREAK] = rq[RQ_BREAK];
    set_v[ST_MUTE] = i_mute_wakeup;
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b)
      flags <= RST_STATUS;
    else if (i_ce)
      flags <= (flags & ~clr_v) | set_v;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  ack_single_a: assert property (o_ack && i_ce |=> !o_ack)
    else $error("ack held for more than one cycle");
  req_reads_zero_a: assert property (o_ack && !i_we && hit(i_adr, OFS_REQUEST) |-> o_dat == '0)
    else $error("request register read not zero");
  // A restart in the expiry cycle keeps the counter running
  timeout_flag_a: assert property (i_ce && tmo_hit && !(sc ? i_start_bit : i_rx_byte_done) |=> flags[ST_TIMEOUT] && !tmo_run)
    else $error("timeout expiry did not set flag");
  blk_rx_off_a: assert property (i_ce && !ctrl[CT_RX_EN] |=> blk_cnt == '0)
    else $error("block counter not cleared with receiver off");
  blk_txbe_a: assert property (i_ce && sc && !flags[ST_TXBE] |=> blk_cnt == '0)
    else $error("block counter not cleared in smart-card mode");
  eob_set_a: assert property (i_ce && eob_hit |=> flags[ST_EOB] && (o_end_of_block_irq == ctrl[CT_EOB_IE]))
    else $error("end of block not flagged");
  break_set_a: assert property (i_ce && rq[RQ_BREAK] |=> o_break_pending)
    else $error("break request not pending");
  rx_flush_a: assert property (i_ce && rq[RQ_RX_FLUSH] && !i_rx_byte_done |=> !flags[ST_RXNE] && o_rx_flush)
    else $error("receive flush failed");
  tx_flush_a: assert property (i_ce && rq[RQ_TX_FLUSH] |=> flags[ST_TXBE] && o_tx_cancel)
    else $error("transmit flush failed");
  overrun_a: assert property (i_ce && i_rx_byte_done && flags[ST_RXNE] |=> flags[ST_OVERRUN])
    else $error("overrun not flagged");
  parity_sticky_a: assert property (flags[ST_PARITY] && !(i_ce && clr_v[ST_PARITY]) |=> flags[ST_PARITY])
    else $error("parity flag lost without clear");
  cts_change_a: assert property (i_ce && (cts_s2 != cts_s3) |=> flags[ST_CTS])
    else $error("clear-to-send change missed");

  // Every event except end of block beats a clear that lands in the same cycle
  parity_set_a: assert property (i_ce && i_parity_err |=> flags[ST_PARITY])
    else $error("parity error not flagged");
  framing_set_a: assert property (i_ce && i_frame_err |=> flags[ST_FRAMING])
    else $error("framing error not flagged");
  noise_set_a: assert property (i_ce && i_noise |=> flags[ST_NOISE])
    else $error("noise not flagged");
  idle_set_a: assert property (i_ce && i_idle |=> flags[ST_IDLE])
    else $error("idle line not flagged");
  idle_clear_a: assert property (i_ce && clr_v[ST_IDLE] && !i_idle |=> !flags[ST_IDLE])
    else $error("idle flag not cleared");
  rxne_set_a: assert property (i_ce && i_rx_byte_done |=> flags[ST_RXNE])
    else $error("receive buffer load not flagged");
  txc_set_a: assert property (i_ce && i_tx_last_done && flags[ST_TXBE] |=> flags[ST_TXC])
    else $error("transmit complete not flagged");
  txbe_clear_a: assert property (i_ce && data_wr && !i_tx_shift_load && !rq[RQ_TX_FLUSH] |=> !flags[ST_TXBE])
    else $error("transmit empty not cleared by data write");
  tx_write_a: assert property (i_ce && data_wr |=> o_tx_write)
    else $error("transmit write pulse missing");
  lin_set_a: assert property (i_ce && i_lin_break |=> flags[ST_LIN])
    else $error("LIN break not flagged");
  autobaud_req_a: assert property (i_ce && rq[RQ_AUTOBAUD] && !i_autobaud_done |=> !flags[ST_AUTOBAUD] && o_autobaud_run)
    else $error("autobaud request failed");
  mute_req_a: assert property (i_ce && rq[RQ_MUTE] && !i_mute_wakeup |=> !flags[ST_MUTE] && o_mute_enter)
    else $error("mute request failed");
  timeout_off_a: assert property (i_ce && timeout_reg[TMO_LSB +: TMO_W] == '0 |=> !tmo_run)
    else $error("timeout ran with zero value");
  blk_eob_clr_a: assert property (i_ce && fc_eob |=> blk_cnt == '0)
    else $error("block counter not cleared by end-of-block clear");
  req_pulse_a: assert property (i_ce && !(wr && hit(i_adr, OFS_REQUEST)) |-> rq == '0)
    else $error("request pulse without write");

  timeout_fire_c: cover property (i_ce && tmo_hit);
  eob_reach_c: cover property (i_ce && eob_hit);
  flag_clear_c: cover property (wr && hit(i_adr, OFS_FLAG_CLR) ##1 !flags[ST_PARITY]);
  req_write_c: cover property (i_ce && rq != '0);
  overrun_c: cover property (i_ce && i_rx_byte_done && flags[ST_RXNE]);
endmodule

// ===== uts_pkg.sv
package uts_pkg;
  localparam logic [7:0] OFS_TIMEOUT = 8'h14;
  localparam logic [7:0] OFS_REQUEST = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_FLAG_CLR = 8'h20;
  localparam logic [7:0] OFS_CONTROL = 8'h24;
  localparam logic [7:0] OFS_DATA = 8'h28;
  localparam int TMO_LSB = 0;
  localparam int TMO_W = 24;
  localparam int BLOCK_LENGTH_LSB = 24;
  localparam int BLOCK_LENGTH_W = 8;
  localparam int RQ_AUTOBAUD = 0;
  localparam int RQ_BREAK = 1;
  localparam int RQ_MUTE = 2;
  localparam int RQ_RX_FLUSH = 3;
  localparam int RQ_TX_FLUSH = 4;
  localparam int RQ_W = 5;
  localparam int ST_PARITY = 0;
  localparam int ST_FRAMING = 1;
  localparam int ST_NOISE = 2;
  localparam int ST_OVERRUN = 3;
  localparam int ST_IDLE = 4;
  localparam int ST_RXNE = 5;
  localparam int ST_TXC = 6;
  localparam int ST_TXBE = 7;
  localparam int ST_LIN = 8;
  localparam int ST_CTS = 9;
  localparam int ST_TIMEOUT = 11;
  localparam int ST_EOB = 12;
  localparam int ST_AUTOBAUD = 15;
  localparam int ST_BREAK = 18;
  localparam int ST_MUTE = 19;
  localparam logic [31:0] FC_MASK = 32'h0000_1b5f;
  localparam int CT_SMARTCARD = 0;
  localparam int CT_RX_EN = 1;
  localparam int CT_LIN_IE = 2;
  localparam int CT_EOB_IE = 3;
  localparam int CT_W = 4;
  localparam logic [31:0] RST_TIMEOUT = 32'h0000_0000;
  localparam logic [31:0] RST_STATUS = 32'h0200_00c0;
  localparam logic [CT_W-1:0] RST_CONTROL = 4'h0;
  localparam logic [8:0] BLOCK_EXTRA = 9'h004;
endpackage

// ===== uts_line_model.sv
module uts_line_model (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [11:0] i_ev,
  input wire logic i_cts_b,
  output logic [11:0] o_ev,
  output logic o_tick,
  output logic o_cts_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div;
  // Baud clock runs free, one tick per four system clocks
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      div <= 2'h0;
      o_tick <= 1'b0;
    end
    else
    begin
      div <= div + 2'h1;
      o_tick <= (div == 2'h3);
    end
  end
  // Events leave as one-cycle pulses, as a real receiver would give them
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_ev <= 12'h000;
      o_cts_b <= 1'b1;
    end
    else
    begin
      o_ev <= i_ev;
      o_cts_b <= i_cts_b;
    end
  end
endmodule

// ===== uts_core_bench.sv
module uts_core_bench
  import uts_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, ack, cts_b = 1, pcts, tick;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, e;
  logic [11:0] evr = 12'h000, pev;
  logic [8:0] rxd = 9'h000, txd;
  logic sc_o, lin_irq, eob_irq, brk, receiver_enable, ce = 1;
  logic [4:0] rqp;
  int seen_p[5];
  int mismatches = 0, num_checks = 0, cycles = 0, sc = 0, block_length = 0, blk = 0;
  int fl[5] = '{0, 1, 2, 4, 8};
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  uts_line_model u_line (.i_clk(clk), .i_rst_b(rst_b), .i_ev(evr), .i_cts_b(cts_b), .o_ev(pev),
    .o_tick(tick), .o_cts_b(pcts));
  uts_core u_dut (.i_clk(clk), .i_rst_b(rst_b), .i_ce(ce), .i_cyc(cyc), .i_stb(stb), .i_we(we),
    .i_adr(adr), .i_sel(4'hf), .i_dat(wdat), .o_dat(rdat), .o_ack(ack), .i_baud_tick(tick),
    .i_start_bit(pev[5]), .i_rx_byte_done(pev[3]), .i_rx_data(rxd), .i_parity_err(pev[0]),
    .i_frame_err(pev[1]), .i_noise(pev[2]), .i_idle(pev[4]), .i_lin_break(pev[8]),
    .i_tx_shift_load(pev[7]), .i_tx_last_done(pev[6]), .i_break_stop_sent(pev[9]),
    .i_autobaud_done(pev[10]), .i_mute_wakeup(pev[11]), .i_clear_to_send_input_b(pcts),
    .o_tx_data(txd), .o_tx_write(rqp[1]), .o_autobaud_run(rqp[0]), .o_mute_enter(rqp[2]), .o_rx_flush(rqp[3]),
    .o_tx_cancel(rqp[4]), .o_break_pending(brk), .o_smartcard_mode(sc_o), .o_receiver_enable(receiver_enable),
    .o_lin_break_irq(lin_irq), .o_end_of_block_irq(eob_irq));
  // Pulses last one cycle, so count them at every edge
  always @(posedge clk)
    foreach (rqp[i])
      if (rqp[i] === 1'b1)
        seen_p[i]++;
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      complete_run();
    end
  end
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask
  // Slave latency is not assumed; a wait ends after 50 cycles without ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int t;
    t = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1 && ++t < 50);
    if (t == 50)
      chk("ack", 1, 0);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string n);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    chk(n, x, r);
    if (a == OFS_DATA)
      e[ST_RXNE] = 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
    case (a)
      OFS_TIMEOUT: block_length = d[31:24];
      OFS_REQUEST: e = (e & ~{12'h0, d[2], 3'h0, d[0], 15'h0}) | {13'h0, d[1], 10'h0, d[4], 7'h0};
      OFS_FLAG_CLR: e = e & ~(d & FC_MASK);
      OFS_DATA: e[7:6] = 2'h0;
      OFS_CONTROL: sc = d[0];
      default: ;
    endcase
    if (a == OFS_REQUEST && d[3])
      e[ST_RXNE] = 1'b0;
    if ((a == OFS_FLAG_CLR && d[12]) || (a == OFS_CONTROL && !d[1]))
      blk = 0;
  endtask
  task automatic ev(input int k);
    @(posedge clk);
    evr[k] <= 1'b1;
    @(posedge clk);
    evr <= 12'h000;
    case (k)
      0, 1, 2, 4, 8: e[k] = 1'b1;
      3:
      begin
        e[ST_OVERRUN] = e[ST_OVERRUN] | e[ST_RXNE];
        e[ST_RXNE] = 1'b1;
        blk = blk + sc;
        if (sc != 0 && blk == block_length + 4)
          e[ST_EOB] = 1'b1;
      end
      6: e[ST_TXC] = e[ST_TXC] | e[ST_TXBE];
      7: e[ST_TXBE] = 1'b1;
      9: e[ST_BREAK] = 1'b0;
      10: e[ST_AUTOBAUD] = 1'b1;
      11: e[ST_MUTE] = 1'b1;
      default: ;
    endcase
    repeat (4) @(posedge clk);
  endtask
  initial
  begin
    logic [31:0] d;
    void'($urandom(90));
    e = RST_STATUS;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    rd(OFS_TIMEOUT, 32'h0, "timeout");
    rd(OFS_STATUS, e, "status");
    d = $urandom | 32'h100;
    wr(OFS_TIMEOUT, d);
    rd(OFS_TIMEOUT, d, "timeout");
    wr(OFS_TIMEOUT, 32'h0);
    wr(8'h30, d);
    rd(8'h30, 32'h0, "unmapped");
    wr(OFS_CONTROL, 32'h4);
    foreach (fl[i])
    begin
      ev(fl[i]);
      rd(OFS_STATUS, e, "flag_set");
      chk("lin_irq", e[ST_LIN], lin_irq);
      wr(OFS_FLAG_CLR, 32'h1 << fl[i]);
      rd(OFS_STATUS, e, "flag_clr");
    end
    ev(11);
    ev(10);
    ev(3);
    wr(OFS_DATA, d);
    chk("tx_data", d[8:0], txd);
    for (int b = 0; b < RQ_W; b++)
    begin
      seen_p = '{0, 0, 0, 0, 0};
      wr(OFS_REQUEST, 32'h1 << b);
      rd(OFS_STATUS, e, "request_effect");
      chk("request_pulse", b != 1, seen_p[b]);
      rd(OFS_REQUEST, 32'h0, "request_read");
    end
    chk("break", e[ST_BREAK], brk);
    ev(9);
    ev(6);
    rd(OFS_STATUS, e, "tx_done");
    wr(OFS_DATA, 32'h0);
    ev(6);
    rd(OFS_STATUS, e, "tx_busy");
    ev(7);
    rxd <= 9'($urandom);
    ev(3);
    ev(3);
    rd(OFS_STATUS, e, "overrun");
    rd(OFS_DATA, {23'h0, rxd}, "rx_data");
    rd(OFS_STATUS, e, "rx_read");
    cts_b <= 1'b0;
    repeat (8) @(posedge clk);
    e[ST_CTS] = 1'b1;
    rd(OFS_STATUS, e, "cts");
    wr(OFS_FLAG_CLR, 32'h200);
    // Clock enable low must freeze every flag
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    rd(OFS_STATUS, e, "freeze");
    // Start bit halts any old count before a short value goes in
    ev(5);
    wr(OFS_TIMEOUT, 32'h5);
    ev(3);
    rd(OFS_STATUS, e, "timeout_early");
    repeat (30) @(posedge clk);
    e[ST_TIMEOUT] = 1'b1;
    rd(OFS_STATUS, e, "timeout_late");
    wr(OFS_TIMEOUT, 32'h0100_0000);
    wr(OFS_FLAG_CLR, 32'h800);
    wr(OFS_CONTROL, 32'hb);
    chk("smartcard", 1, sc_o);
    chk("rx_enable", 1, receiver_enable);
    for (int p = 0; p < 2; p++)
    begin
      if (p == 1)
        wr(OFS_FLAG_CLR, 32'h1000);
      repeat (5)
      begin
        ev(3);
        rd(OFS_STATUS, e, "block");
        chk("eob_irq", e[ST_EOB], eob_irq);
      end
    end
    complete_run();
  end
endmodule
